// ===== verilog/pst_pkg.sv
// Package for the status and trim register group of the PFC controller
package pst_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int ADC_W = 12;
  localparam int PWM_W = 10;
  localparam int POWER_W = 16;

  // Register offsets
  localparam logic [15:0] OFS_CS_GAIN_TRIM_HIGH = 16'hfe7e;
  localparam logic [15:0] OFS_CS_OFFSET_TRIM_HIGH = 16'hfe7f;
  localparam logic [15:0] OFS_STICKY_FLAGS_ZERO = 16'hfe80;
  localparam logic [15:0] OFS_STICKY_FLAGS_ONE = 16'hfe81;
  localparam logic [15:0] OFS_STICKY_FLAGS_TWO = 16'hfe82;
  localparam logic [15:0] OFS_DUTY_VALUE_READBACK = 16'hfe84;
  localparam logic [15:0] OFS_MAINS_PERIOD_READBACK = 16'hfe85;
  localparam logic [15:0] OFS_TEMPERATURE_READBACK = 16'hfe86;
  localparam logic [15:0] OFS_METER_OFFSET_TRIM_HIGH = 16'hfe8e;

  // Reset values
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // Trim field layout: sign on top, magnitude below
  localparam int TRIM_SIGN_BIT = 7;
  localparam int TRIM_MAG_W = 7;

  // Implemented bits of each sticky register, reserved read as zero
  localparam logic [7:0] FLAGS_ZERO_MASK = 8'hff;
  localparam logic [7:0] FLAGS_ONE_MASK = 8'h7f;
  localparam logic [7:0] FLAGS_TWO_MASK = 8'h3e;

  // Value reported when the line period cannot be measured
  localparam logic [7:0] PERIOD_MAX = 8'hff;
  // One period count, nanoseconds (163.84 us)
  localparam int PERIOD_STEP_NS = 163840;

  // Gain trim magnitude scale: correction = sample * mag / 2**GAIN_SHIFT
  localparam int GAIN_SHIFT = 10;
  // Meter offset step is 0.0625/128 = 1/2048 of full input power
  localparam int METER_STEP_DIV_LOG2 = 11;
  localparam int METER_STEP_SHIFT = POWER_W - METER_STEP_DIV_LOG2;

  // Event conditions from the control loops, each setting one sticky bit
  typedef struct packed {
    logic max_modulation;
    logic min_modulation;
    logic divider_open_fault;
    logic quick_overvoltage_trip;
    logic input_sag_flag;
    logic ramp_fast_filter;
    logic inrush_relay_off;
    logic nvm_unlocked;
    logic nvm_check_fail;
    logic address_marginal;
    logic high_line;
    logic quick_overcurrent_trip;
    logic sync_locked;
    logic low_power;
    logic fast_loop_active;
    logic core_rail_over;
    logic supply_rail_over;
    logic supply_rail_under;
  } pst_events_t;

  // Register access port from the management bus engine
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pst_req_t;

  typedef struct packed {
    logic [7:0] gain_trim;
    logic [7:0] offset_trim;
    logic [7:0] meter_trim;
    logic [7:0] flags_zero;
    logic [7:0] flags_one;
    logic [7:0] flags_two;
    logic [DATA_W-1:0] rdata;
    logic wr_rejected;
    logic [15:0] adc_corr;
    logic [POWER_W-1:0] power_corr;
    logic [7:0] period_used;
  } pst_state_t;

endpackage

// ===== verilog/pst_status_trim_regs.sv
// Status flags, monitors and calibration trims of the PFC controller
// Function
// - Current-sense trim writes are refused unless write access is unlocked.
// - Gain trim top bit is sign, one negative; low seven bits magnitude.
// - Eight-bit high-range offset trim is always subtracted from the raw sample.
// - Sticky flags stay set after their condition goes away.
// - Reading a sticky register returns it then clears only that register.
// - Register zero bit seven on upper modulation limit, bit six lower.
// - Register zero bit five when a sense divider seems open or faulty.
// - Register zero bit four when overvoltage comparator threshold is crossed.
// - Unknown line period uses maximum value and sets register zero bit three.
// - Register zero bit two while input is below turn-on level.
// - Register zero bit one during fast-filter ramp-up, bit zero relay off.
// - Register one bit six memory unlocked, bit five download check failed.
// - Register one bit four when address resistor is near a boundary.
// - Register one bit three when input exceeds the high line threshold.
// - Register one bit two on overcurrent trip, bit one on sync lock.
// - Register one bit zero is programmable input flag combination, pin low.
// - Register two bits three, two, one: core over, supply over, under.
// - Register two bit five low power, bit four fast loop active.
// - Duty readback returns the upper eight of ten duty bits.
// - Period readback is an eight-bit count of 163.84 us steps.
// - Temperature readback is sixteen bits holding a twelve-bit result.
// - Meter offset trim is sign plus seven-bit 1/2048 full power steps.
module pst_status_trim_regs (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire pst_pkg::pst_req_t req_i,
  input wire logic trim_unlock_i,
  input wire pst_pkg::pst_events_t events_i,
  input wire logic [3:0] input_flags_i,
  input wire logic [3:0] input_good_sel_i,
  input wire logic period_valid_i,
  input wire logic [7:0] period_meas_i,
  input wire logic [pst_pkg::PWM_W-1:0] duty_i,
  input wire logic [pst_pkg::ADC_W-1:0] temp_adc_i,
  input wire logic [pst_pkg::ADC_W-1:0] cs_adc_raw_i,
  input wire logic [pst_pkg::POWER_W-1:0] power_raw_i,
  output logic [pst_pkg::DATA_W-1:0] rdata_o,
  output logic wr_rejected_o,
  output logic [15:0] cs_adc_corr_o,
  output logic [pst_pkg::POWER_W-1:0] power_corr_o,
  output logic [7:0] period_used_o
);
  import pst_pkg::*;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b001,
    SEL_CS_TRIM = 3'b010,
    SEL_OTHER = 3'b100
  } pst_sel_t;

  // Classifies an address for write protection
  function automatic pst_sel_t reg_class(input logic [ADDR_W-1:0] a);
    pst_sel_t s;
    s = SEL_NONE;
    if (a == OFS_CS_GAIN_TRIM_HIGH || a == OFS_CS_OFFSET_TRIM_HIGH) begin
      s = SEL_CS_TRIM;
    end else if (a == OFS_METER_OFFSET_TRIM_HIGH) begin
      s = SEL_OTHER;
    end
    return s;
  endfunction

  logic rst_sync1_q;
  logic rst_sync2_q;
  pst_state_t st_q;
  pst_state_t st_d;

  // Reset released through two flops
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  logic [7:0] set_zero;
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic period_unknown;
  logic input_good_flag;
  logic signed [21:0] off_corr;
  logic signed [21:0] gain_corr;
  logic signed [21:0] adc_sum;
  logic signed [17:0] pwr_step;
  logic signed [17:0] pwr_sum;
  pst_sel_t wsel;

  always_comb begin
    period_unknown = !period_valid_i;
    input_good_flag = |(input_flags_i & input_good_sel_i);
    set_zero = {events_i.max_modulation,
                events_i.min_modulation,
                events_i.divider_open_fault,
                events_i.quick_overvoltage_trip,
                period_unknown,
                events_i.input_sag_flag,
                events_i.ramp_fast_filter,
                events_i.inrush_relay_off} & FLAGS_ZERO_MASK;
    set_one = {1'b0,
               events_i.nvm_unlocked,
               events_i.nvm_check_fail,
               events_i.address_marginal,
               events_i.high_line,
               events_i.quick_overcurrent_trip,
               events_i.sync_locked,
               input_good_flag} & FLAGS_ONE_MASK;
    set_two = {2'b00,
               events_i.low_power,
               events_i.fast_loop_active,
               events_i.core_rail_over,
               events_i.supply_rail_over,
               events_i.supply_rail_under,
               1'b0} & FLAGS_TWO_MASK;

    // Offset always subtracted, then signed gain correction applied
    off_corr = 22'(signed'({1'b0, cs_adc_raw_i}))
             - 22'(signed'({1'b0, st_q.offset_trim}));
    gain_corr = (off_corr
              * 22'(signed'({1'b0, st_q.gain_trim[TRIM_MAG_W-1:0]})))
              >>> GAIN_SHIFT;
    adc_sum = st_q.gain_trim[TRIM_SIGN_BIT] ? off_corr - gain_corr
                                            : off_corr + gain_corr;

    // Meter offset in 1/2048 full-power steps, clamped to range
    pwr_step = 18'(st_q.meter_trim[TRIM_MAG_W-1:0]) <<< METER_STEP_SHIFT;
    pwr_sum = st_q.meter_trim[TRIM_SIGN_BIT]
            ? 18'({2'b00, power_raw_i}) - pwr_step
            : 18'({2'b00, power_raw_i}) + pwr_step;

    wsel = reg_class(req_i.addr);
  end

  always_comb begin
    st_d = st_q;
    st_d.wr_rejected = 1'b0;
    st_d.rdata = '0;

    // Hold flags; a read clears, but a live event still sets
    st_d.flags_zero = st_q.flags_zero | set_zero;
    st_d.flags_one = st_q.flags_one | set_one;
    st_d.flags_two = st_q.flags_two | set_two;

    if (req_i.rd) begin
      case (req_i.addr)
        OFS_CS_GAIN_TRIM_HIGH: st_d.rdata = {8'h00, st_q.gain_trim};
        OFS_CS_OFFSET_TRIM_HIGH: st_d.rdata = {8'h00, st_q.offset_trim};
        OFS_STICKY_FLAGS_ZERO: begin
          st_d.rdata = {8'h00, st_q.flags_zero};
          st_d.flags_zero = set_zero;
        end
        OFS_STICKY_FLAGS_ONE: begin
          st_d.rdata = {8'h00, st_q.flags_one};
          st_d.flags_one = set_one;
        end
        OFS_STICKY_FLAGS_TWO: begin
          st_d.rdata = {8'h00, st_q.flags_two};
          st_d.flags_two = set_two;
        end
        OFS_DUTY_VALUE_READBACK: begin
          st_d.rdata = {8'h00, duty_i[PWM_W-1:PWM_W-8]};
        end
        OFS_MAINS_PERIOD_READBACK: begin
          st_d.rdata = {8'h00, st_q.period_used};
        end
        OFS_TEMPERATURE_READBACK: begin
          st_d.rdata = {{(DATA_W-ADC_W){1'b0}}, temp_adc_i};
        end
        OFS_METER_OFFSET_TRIM_HIGH: st_d.rdata = {8'h00, st_q.meter_trim};
        default: st_d.rdata = '0;
      endcase
    end

    if (req_i.wr) begin
      case (wsel)
        SEL_CS_TRIM: begin
          // Calibration is protected against stray writes
          if (!trim_unlock_i) begin
            st_d.wr_rejected = 1'b1;
          end else if (req_i.addr == OFS_CS_GAIN_TRIM_HIGH) begin
            st_d.gain_trim = req_i.wdata;
          end else begin
            st_d.offset_trim = req_i.wdata;
          end
        end
        SEL_OTHER: st_d.meter_trim = req_i.wdata;
        SEL_NONE: st_d.wr_rejected = 1'b0;
        default: st_d.wr_rejected = 1'b0;
      endcase
    end

    // Unmeasurable period falls back to the longest count
    st_d.period_used = period_unknown ? PERIOD_MAX : period_meas_i;

    st_d.adc_corr = adc_sum[15:0];
    if (pwr_sum < 0) begin
      st_d.power_corr = '0;
    end else if (pwr_sum > 18'sh0ffff) begin
      st_d.power_corr = '1;
    end else begin
      st_d.power_corr = pwr_sum[POWER_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      st_q <= '0;
      st_q.gain_trim <= TRIM_RST;
      st_q.offset_trim <= TRIM_RST;
      st_q.meter_trim <= TRIM_RST;
      st_q.flags_zero <= FLAGS_RST;
      st_q.flags_one <= FLAGS_RST;
      st_q.flags_two <= FLAGS_RST;
      st_q.period_used <= PERIOD_MAX;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign wr_rejected_o = st_q.wr_rejected;
  assign cs_adc_corr_o = st_q.adc_corr;
  assign power_corr_o = st_q.power_corr;
  assign period_used_o = st_q.period_used;

endmodule

// ===== testbench/pst_status_trim_regs_properties.sv
// Concurrent checks on the register port and the monitors
module pst_status_trim_regs_properties (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire pst_pkg::pst_req_t req_i,
  input wire logic trim_unlock_i,
  input wire pst_pkg::pst_events_t events_i,
  input wire logic period_valid_i,
  input wire logic [7:0] period_meas_i,
  input wire logic [pst_pkg::PWM_W-1:0] duty_i,
  input wire logic [pst_pkg::ADC_W-1:0] temp_adc_i,
  input wire logic [pst_pkg::DATA_W-1:0] rdata_o,
  input wire logic wr_rejected_o,
  input wire logic [7:0] period_used_o
);
  import pst_pkg::*;
  logic [1:0] up_q;
  logic live, cs_wr, rd0, quiet;
  // Internal reset trails the pin by two edges
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up_q <= 2'b00;
    end else begin
      up_q <= {up_q[0], 1'b1};
    end
  end
  assign live = up_q[1];
  assign cs_wr = req_i.wr && !trim_unlock_i &&
    (req_i.addr inside {OFS_CS_GAIN_TRIM_HIGH, OFS_CS_OFFSET_TRIM_HIGH});
  assign rd0 = req_i.rd && req_i.addr == OFS_STICKY_FLAGS_ZERO;
  assign quiet = events_i == '0 && period_valid_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_locked_reject: assert property (live && cs_wr |=> wr_rejected_o)
    else $error("locked trim write not refused");
  a_no_false_reject: assert property (!cs_wr |=> !wr_rejected_o)
    else $error("refusal without a locked trim write");
  a_period_unknown: assert property (
    live && !period_valid_i |=> period_used_o == 8'hff)
    else $error("unknown period not at maximum");
  a_period_count: assert property (
    live && period_valid_i |=> period_used_o == $past(period_meas_i))
    else $error("period count not passed on");
  a_duty_msbs: assert property (
    live && req_i.rd && req_i.addr == OFS_DUTY_VALUE_READBACK
    |=> rdata_o == 16'($past(duty_i) >> 2))
    else $error("duty readback wrong");
  a_temp_whole: assert property (
    live && req_i.rd && req_i.addr == OFS_TEMPERATURE_READBACK
    |=> rdata_o == 16'($past(temp_adc_i)))
    else $error("temperature readback wrong");
  a_flag_sticky: assert property (
    live && events_i.max_modulation ##1 rd0 |=> rdata_o[7])
    else $error("upper modulation flag lost");
  a_read_clears: assert property (
    live && rd0 && quiet ##1 quiet ##1 rd0 && quiet |=> rdata_o == 16'h0)
    else $error("flags not cleared by read");
endmodule
bind pst_status_trim_regs pst_status_trim_regs_properties i_pst_props (.*);

// ===== testbench/pst_host_model.sv
// Host model: one register access at a time on the request port
module pst_host_model (
  input wire logic clk_sys_i,
  input wire logic [15:0] rdata_i,
  input wire logic rej_i,
  output pst_pkg::pst_req_t req_o,
  output logic unlock_o
);
  import pst_pkg::*;
  logic [15:0] rdv;
  logic rejv;
  initial begin
    req_o = '0;
    unlock_o = 1'b0;
  end
  // Request stands one cycle, answer taken after the next edge
  task automatic xfer(input logic [15:0] a, input logic w,
      input logic [7:0] d, input logic ul);
    @(posedge clk_sys_i);
    unlock_o <= ul;
    req_o <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk_sys_i);
    req_o <= '0;
    #1;
    rdv = rdata_i;
    rejv = rej_i;
  endtask
endmodule

// ===== testbench/pst_status_trim_regs_tb.sv
// Self-checking bench for the status and trim register group
module pst_status_trim_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pst_pkg::*;
  logic clk_sys_i, rst_b_i, trim_unlock_i, period_valid_i, wr_rejected_o;
  pst_req_t req_i;
  pst_events_t events_i;
  logic [3:0] input_flags_i, input_good_sel_i;
  logic [7:0] period_meas_i, period_used_o;
  logic [9:0] duty_i;
  logic [11:0] temp_adc_i, cs_adc_raw_i;
  logic [15:0] power_raw_i, rdata_o, cs_adc_corr_o, power_corr_o;
  logic [31:0] r;
  logic [7:0] m [3], c [3];
  int err_total, checks_done, seed, gain, offs, mtr;
  pst_status_trim_regs i_pst_status_trim_regs (.*);
  pst_host_model i_pst_host_model (.clk_sys_i(clk_sys_i),
    .rdata_i(rdata_o), .rej_i(wr_rejected_o), .req_o(req_i),
    .unlock_o(trim_unlock_i));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic void set_c();
    pst_events_t e;
    e = events_i;
    c[0] = {e.max_modulation, e.min_modulation, e.divider_open_fault,
      e.quick_overvoltage_trip, !period_valid_i, e.input_sag_flag,
      e.ramp_fast_filter, e.inrush_relay_off};
    c[1] = {1'b0, e.nvm_unlocked, e.nvm_check_fail, e.address_marginal,
      e.high_line, e.quick_overcurrent_trip, e.sync_locked,
      |(input_flags_i & input_good_sel_i)};
    c[2] = {2'b00, e.low_power, e.fast_loop_active, e.core_rail_over,
      e.supply_rail_over, e.supply_rail_under, 1'b0};
  endfunction
  function automatic logic [15:0] exp_rd(input logic [15:0] a);
    case (a)
      OFS_CS_GAIN_TRIM_HIGH: return 16'(gain);
      OFS_CS_OFFSET_TRIM_HIGH: return 16'(offs);
      OFS_METER_OFFSET_TRIM_HIGH: return 16'(mtr);
      OFS_STICKY_FLAGS_ZERO, OFS_STICKY_FLAGS_ONE,
      OFS_STICKY_FLAGS_TWO: return {8'h00, m[a[1:0]]};
      OFS_DUTY_VALUE_READBACK: return {8'h00, duty_i[9:2]};
      OFS_MAINS_PERIOD_READBACK:
        return {8'h00, period_valid_i ? period_meas_i : 8'hff};
      OFS_TEMPERATURE_READBACK: return {4'h0, temp_adc_i};
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [15:0] cs_exp();
    int d, t;
    d = int'(cs_adc_raw_i) - offs;
    t = (d * (gain & 127)) >>> 10;
    return 16'(gain[7] ? d - t : d + t);
  endfunction
  function automatic logic [15:0] pw_exp();
    int p;
    p = int'(power_raw_i) + (mtr[7] ? -32 : 32) * (mtr & 127);
    return p < 0 ? 16'h0000 : p > 65535 ? 16'hffff : 16'(p);
  endfunction
  task automatic rd_chk(input logic [15:0] a);
    i_pst_host_model.xfer(a, 1'b0, 8'h00, 1'b0);
    chk(i_pst_host_model.rdv, exp_rd(a));
    // Read of a sticky register leaves only what is still present
    if (a inside {[OFS_STICKY_FLAGS_ZERO:OFS_STICKY_FLAGS_TWO]})
      m[a[1:0]] = c[a[1:0]];
  endtask
  task automatic wr(input logic [15:0] a, input int d, input logic ul);
    i_pst_host_model.xfer(a, 1'b1, 8'(d), ul);
    chk(16'(i_pst_host_model.rejv), 16'(!ul && a < 16'hfe80));
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #50us;
    err_total++;
    complete_run();
  end
  initial begin
    seed = 36496;
    {rst_b_i, events_i, input_flags_i, input_good_sel_i} = '0;
    {period_valid_i, period_meas_i, duty_i} = {1'b1, 8'h40, 10'h2a5};
    {temp_adc_i, cs_adc_raw_i, power_raw_i} = {12'h9c3, 12'h800, 16'h8000};
    {gain, offs, mtr} = '0;
    m = '{default: 8'h00};
    c = m;
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    for (int a = 16'hfe7e; a <= 16'hfe8f; a++) rd_chk(16'(a));
    wr(OFS_CS_GAIN_TRIM_HIGH, 8'hc3, 1'b0);
    wr(OFS_CS_OFFSET_TRIM_HIGH, 8'h3c, 1'b0);
    rd_chk(OFS_CS_GAIN_TRIM_HIGH);
    rd_chk(OFS_CS_OFFSET_TRIM_HIGH);
    for (int k = 0; k < 8; k++) begin
      r = k == 0 ? '1 : $random(seed);
      gain = int'(r[7:0]);
      offs = int'(r[15:8]);
      mtr = int'(r[23:16]);
      wr(OFS_CS_GAIN_TRIM_HIGH, gain, 1'b1);
      wr(OFS_CS_OFFSET_TRIM_HIGH, offs, 1'b1);
      wr(OFS_METER_OFFSET_TRIM_HIGH, mtr, 1'b0);
      @(posedge clk_sys_i);
      r = $random(seed);
      cs_adc_raw_i <= r[11:0];
      power_raw_i <= r[31:16];
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk(cs_adc_corr_o, cs_exp());
      chk(power_corr_o, pw_exp());
      rd_chk(OFS_METER_OFFSET_TRIM_HIGH);
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys_i);
      r = $random(seed);
      {events_i, input_flags_i, input_good_sel_i} <= r[25:0];
      {period_valid_i, period_meas_i, duty_i} <= {r[26], r[31:24], r[9:0]};
      temp_adc_i <= r[31:20];
      repeat (2) @(posedge clk_sys_i);
      #1;
      set_c();
      for (int i = 0; i < 3; i++) m[i] |= c[i];
      chk(16'(period_used_o), 16'(exp_rd(16'hfe85)));
      for (int a = 16'hfe80; a <= 16'hfe86; a++) rd_chk(16'(a));
      @(posedge clk_sys_i);
      {events_i, input_flags_i, period_valid_i} <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      set_c();
      for (int i = 0; i < 6; i++) rd_chk(16'hfe80 + 16'(i / 2));
    end
    complete_run();
  end
endmodule
